//--- design/core_interrupt_control.v
// Purpose: interrupt enable/flag registers and request to the core
// Assumes: one clock, synchronous active-high reset, event inputs one-cycle pulses
// Notes: register port: read data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "core_irq_regs.vh"
module core_interrupt_control (
  input wire i_clock,               // core clock, 250 MHz
  input wire i_reset,               // sync reset, active high
  input wire [`ADDR_W-1:0] i_addr,  // register address
  input wire [7:0] i_wdata,         // write data
  input wire i_wr,                  // write strobe
  input wire i_rd,                  // read strobe
  output reg [7:0] o_rdata,         // read data, cycle after i_rd
  input wire i_timer0_overflow,     // timer0 overflow pulse
  input wire i_port_change,         // port change pulse
  input wire i_ext_pin,             // external interrupt pin level
  input wire i_conv_done,           // converter complete pulse
  input wire i_serial_done,         // serial port pulse
  input wire i_capcmp_event,        // capture/compare pulse
  input wire i_timer2_match,        // timer2 match pulse
  input wire i_timer1_overflow,     // timer1 overflow pulse
  output wire o_core_irq,           // interrupt request to core
  output wire o_irq                 // block status interrupt, level
);
  reg [7:0] core_ctrl_r;
  reg [7:0] periph_en_r;
  reg [7:0] periph_flag_r;
  reg edge_sel_r;
  reg [7:0] status_r;
  reg [7:0] mask_r;
  reg req_prev_r;
  reg [7:0] core_nxt;
  reg [7:0] pflag_nxt;
  reg [7:0] core_set;
  reg [7:0] pflag_set;
  wire ext_edge;
  wire core_term;
  wire periph_term;
  wire wr_core;
  wire wr_pen;
  wire wr_pflag;
  wire lost_evt;
  wire wr_edge;
  wire wr_status;
  wire wr_mask;
  wire rd_core;
  wire rd_pen;
  wire rd_pflag;
  wire rd_edge;
  wire rd_status;
  wire rd_mask;
  wire req_rise;
  wire [7:0] status_set;
  reg [7:0] core_pairs;
  reg [7:0] periph_pairs;
  reg [7:0] status_nxt;
  reg [7:0] pen_nxt;
  reg edge_nxt;
  reg [7:0] mask_nxt;
  reg [7:0] rdata_nxt;

  function is_core_addr;
    input [`ADDR_W-1:0] a;
    begin
      is_core_addr = (a == `CORE_CTRL_ADDR_B0) || (a == `CORE_CTRL_ADDR_B1) ||
                     (a == `CORE_CTRL_ADDR_B2) || (a == `CORE_CTRL_ADDR_B3);
    end
  endfunction

  // enable-type bit: takes the written value, otherwise keeps its own
  function field_next;
    input cur;
    input wr;
    input wbit;
    begin
      field_next = wr ? wbit : cur;
    end
  endfunction

  // flag bit: software may write either value, but a hardware set in the
  // same cycle wins so that no event is lost
  function flag_next;
    input cur;
    input wr;
    input wbit;
    input set;
    begin
      flag_next = field_next(cur, wr, wbit) | set;
    end
  endfunction

  // status bit: write one to clear, hardware set wins
  function sticky_next;
    input cur;
    input clr;
    input set;
    begin
      sticky_next = (cur & ~clr) | set;
    end
  endfunction

  // one source asks for service when both its enable and its flag are set
  function pair_active;
    input en;
    input flag;
    begin
      pair_active = en & flag;
    end
  endfunction

  edge_detect u_edge (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(i_ext_pin),
    .i_rising(edge_sel_r),
    .o_pulse(ext_edge)
  );

  assign wr_core = i_wr & is_core_addr(i_addr);
  assign wr_pen = i_wr & (i_addr == `PERIPH_EN_ADDR);
  assign wr_pflag = i_wr & (i_addr == `PERIPH_FLAG_ADDR);
  assign wr_edge = i_wr & (i_addr == `OPTION_EDGE_ADDR);
  assign wr_status = i_wr & (i_addr == `IRQ_STATUS_ADDR);
  assign wr_mask = i_wr & (i_addr == `IRQ_MASK_ADDR);
  assign rd_core = i_rd & is_core_addr(i_addr);
  assign rd_pen = i_rd & (i_addr == `PERIPH_EN_ADDR);
  assign rd_pflag = i_rd & (i_addr == `PERIPH_FLAG_ADDR);
  assign rd_edge = i_rd & (i_addr == `OPTION_EDGE_ADDR);
  assign rd_status = i_rd & (i_addr == `IRQ_STATUS_ADDR);
  assign rd_mask = i_rd & (i_addr == `IRQ_MASK_ADDR);

  // hardware set sources, independent of enables
  always @* begin
    core_set = 8'h00;
    core_set[`BIT_T0_FLAG] = i_timer0_overflow;
    core_set[`BIT_EXT_FLAG] = ext_edge;
    core_set[`BIT_PORT_FLAG] = i_port_change;
    pflag_set = 8'h00;
    pflag_set[`BIT_CONV] = i_conv_done;
    pflag_set[`BIT_SERIAL] = i_serial_done;
    pflag_set[`BIT_CAPCMP] = i_capcmp_event;
    pflag_set[`BIT_T2] = i_timer2_match;
    pflag_set[`BIT_T1] = i_timer1_overflow;
  end

  // enables follow the write; flags follow the write, then any hardware set
  always @* begin
    core_nxt = 8'h00;
    core_nxt[`BIT_GLOBAL_EN] = field_next(core_ctrl_r[`BIT_GLOBAL_EN], wr_core,
      i_wdata[`BIT_GLOBAL_EN]);
    core_nxt[`BIT_PERIPH_MASTER] = field_next(core_ctrl_r[`BIT_PERIPH_MASTER], wr_core,
      i_wdata[`BIT_PERIPH_MASTER]);
    core_nxt[`BIT_T0_EN] = field_next(core_ctrl_r[`BIT_T0_EN], wr_core,
      i_wdata[`BIT_T0_EN]);
    core_nxt[`BIT_EXT_EN] = field_next(core_ctrl_r[`BIT_EXT_EN], wr_core,
      i_wdata[`BIT_EXT_EN]);
    core_nxt[`BIT_PORT_EN] = field_next(core_ctrl_r[`BIT_PORT_EN], wr_core,
      i_wdata[`BIT_PORT_EN]);
    core_nxt[`BIT_T0_FLAG] = flag_next(core_ctrl_r[`BIT_T0_FLAG], wr_core,
      i_wdata[`BIT_T0_FLAG], core_set[`BIT_T0_FLAG]);
    core_nxt[`BIT_EXT_FLAG] = flag_next(core_ctrl_r[`BIT_EXT_FLAG], wr_core,
      i_wdata[`BIT_EXT_FLAG], core_set[`BIT_EXT_FLAG]);
    core_nxt[`BIT_PORT_FLAG] = flag_next(core_ctrl_r[`BIT_PORT_FLAG], wr_core,
      i_wdata[`BIT_PORT_FLAG], core_set[`BIT_PORT_FLAG]);
    pflag_nxt = 8'h00;
    pflag_nxt[`BIT_CONV] = flag_next(periph_flag_r[`BIT_CONV], wr_pflag,
      i_wdata[`BIT_CONV], pflag_set[`BIT_CONV]);
    pflag_nxt[`BIT_SERIAL] = flag_next(periph_flag_r[`BIT_SERIAL], wr_pflag,
      i_wdata[`BIT_SERIAL], pflag_set[`BIT_SERIAL]);
    pflag_nxt[`BIT_CAPCMP] = flag_next(periph_flag_r[`BIT_CAPCMP], wr_pflag,
      i_wdata[`BIT_CAPCMP], pflag_set[`BIT_CAPCMP]);
    pflag_nxt[`BIT_T2] = flag_next(periph_flag_r[`BIT_T2], wr_pflag,
      i_wdata[`BIT_T2], pflag_set[`BIT_T2]);
    pflag_nxt[`BIT_T1] = flag_next(periph_flag_r[`BIT_T1], wr_pflag,
      i_wdata[`BIT_T1], pflag_set[`BIT_T1]);
  end

  // an event counts as lost if software writes zero to that event's flag bit in the same cycle
  assign lost_evt = (wr_core & |(core_set & ~i_wdata)) |
                    (wr_pflag & |(pflag_set & ~i_wdata));

  // plain control registers: written with unimplemented bits masked to zero, never set by hardware
  always @* begin
    pen_nxt = periph_en_r;
    edge_nxt = edge_sel_r;
    mask_nxt = mask_r;
    if (wr_pen) begin
      pen_nxt = i_wdata & `PERIPH_IMPL_MASK;
    end
    if (wr_edge) begin
      edge_nxt = i_wdata[0];
    end
    if (wr_mask) begin
      mask_nxt = i_wdata & `STATUS_MASK;
    end
  end

  always @(posedge i_clock) begin
    if (i_reset) begin
      // port-change flag has no defined reset; clear it too, as a known value is safer
      core_ctrl_r <= `CORE_CTRL_RESET;
      periph_en_r <= `PERIPH_RESET;
      periph_flag_r <= `PERIPH_RESET;
      edge_sel_r <= `EDGE_RESET;
    end else begin
      core_ctrl_r <= core_nxt;
      periph_flag_r <= pflag_nxt;
      periph_en_r <= pen_nxt;
      edge_sel_r <= edge_nxt;
    end
  end

  // one bit per source that is both enabled and flagged
  always @* begin
    core_pairs = 8'h00;
    core_pairs[`BIT_T0_FLAG] = pair_active(core_ctrl_r[`BIT_T0_EN],
      core_ctrl_r[`BIT_T0_FLAG]);
    core_pairs[`BIT_EXT_FLAG] = pair_active(core_ctrl_r[`BIT_EXT_EN],
      core_ctrl_r[`BIT_EXT_FLAG]);
    core_pairs[`BIT_PORT_FLAG] = pair_active(core_ctrl_r[`BIT_PORT_EN],
      core_ctrl_r[`BIT_PORT_FLAG]);
    periph_pairs = 8'h00;
    periph_pairs[`BIT_CONV] = pair_active(periph_en_r[`BIT_CONV],
      periph_flag_r[`BIT_CONV]);
    periph_pairs[`BIT_SERIAL] = pair_active(periph_en_r[`BIT_SERIAL],
      periph_flag_r[`BIT_SERIAL]);
    periph_pairs[`BIT_CAPCMP] = pair_active(periph_en_r[`BIT_CAPCMP],
      periph_flag_r[`BIT_CAPCMP]);
    periph_pairs[`BIT_T2] = pair_active(periph_en_r[`BIT_T2], periph_flag_r[`BIT_T2]);
    periph_pairs[`BIT_T1] = pair_active(periph_en_r[`BIT_T1], periph_flag_r[`BIT_T1]);
  end

  // global enable gates both terms; peripheral sources also need their master
  assign core_term = core_ctrl_r[`BIT_GLOBAL_EN] & |core_pairs;
  assign periph_term = core_ctrl_r[`BIT_GLOBAL_EN] & core_ctrl_r[`BIT_PERIPH_MASTER] &
    |periph_pairs;
  assign o_core_irq = core_term | periph_term;

  // block's own status: request rising, event lost; write one to clear
  assign req_rise = o_core_irq & ~req_prev_r;
  assign status_set = {6'h00, lost_evt, req_rise};

  always @* begin
    status_nxt = 8'h00;
    status_nxt[`ST_REQ_RISE] = sticky_next(status_r[`ST_REQ_RISE],
      wr_status & i_wdata[`ST_REQ_RISE], status_set[`ST_REQ_RISE]);
    status_nxt[`ST_EVT_LOST] = sticky_next(status_r[`ST_EVT_LOST],
      wr_status & i_wdata[`ST_EVT_LOST], status_set[`ST_EVT_LOST]);
  end

  always @(posedge i_clock) begin
    if (i_reset) begin
      status_r <= 8'h00;
      mask_r <= 8'h00;
      req_prev_r <= 1'b0;
    end else begin
      req_prev_r <= o_core_irq;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
    end
  end
  assign o_irq = |(status_r & mask_r);

  // read mux: unmapped addresses and idle cycles give zero
  always @* begin
    rdata_nxt = 8'h00;
    if (rd_core) begin
      rdata_nxt = core_ctrl_r;
    end
    if (rd_pen) begin
      rdata_nxt = periph_en_r;
    end
    if (rd_pflag) begin
      rdata_nxt = periph_flag_r;
    end
    if (rd_edge) begin
      rdata_nxt = {7'h00, edge_sel_r};
    end
    if (rd_status) begin
      rdata_nxt = status_r;
    end
    if (rd_mask) begin
      rdata_nxt = mask_r;
    end
  end

  // data stand for the one cycle after the read strobe only
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

//--- include/core_irq_regs.vh
// Purpose: register offsets, field positions and reset values of the core interrupt control block
// Assumes: 9-bit data address, 8-bit registers
// Notes: definitions only
`ifndef CORE_IRQ_REGS_VH
`define CORE_IRQ_REGS_VH

`define ADDR_W 9
`define CORE_CTRL_ADDR_B0 9'h00B
`define CORE_CTRL_ADDR_B1 9'h08B
`define CORE_CTRL_ADDR_B2 9'h10B
`define CORE_CTRL_ADDR_B3 9'h18B
`define PERIPH_EN_ADDR 9'h08C
`define PERIPH_FLAG_ADDR 9'h00C
`define OPTION_EDGE_ADDR 9'h1F0
`define IRQ_STATUS_ADDR 9'h1F1
`define IRQ_MASK_ADDR 9'h1F2

// core control bit positions
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_MASTER 6
`define BIT_T0_EN 5
`define BIT_EXT_EN 4
`define BIT_PORT_EN 3
`define BIT_T0_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_PORT_FLAG 0

// peripheral bit positions
`define BIT_CONV 6
`define BIT_SERIAL 3
`define BIT_CAPCMP 2
`define BIT_T2 1
`define BIT_T1 0
`define PERIPH_IMPL_MASK 8'h4F

`define CORE_CTRL_RESET 8'h00
`define PERIPH_RESET 8'h00
`define EDGE_RESET 1'b1

// status register of the block's own events
`define ST_REQ_RISE 0
`define ST_EVT_LOST 1
`define STATUS_MASK 8'h03

`endif

//--- design/edge_detect.v
// Purpose: selectable edge detector for the external interrupt pin
// Assumes: pin already synchronous to i_clock
// Notes: one-cycle pulse on the chosen edge
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input wire i_clock,         // core clock
  input wire i_reset,         // sync reset, active high
  input wire i_pin,           // sampled pin level
  input wire i_rising,        // 1 rising, 0 falling
  output wire o_pulse         // edge seen this cycle
);
  reg prev_r;
  always @(posedge i_clock) begin
    if (i_reset) begin
      prev_r <= i_pin;
    end else begin
      prev_r <= i_pin;
    end
  end
  // history follows the pin during reset, so a pin already high is no edge
  assign o_pulse = i_rising ? (i_pin & ~prev_r) : (~i_pin & prev_r);
endmodule
`default_nettype wire

//--- verification/core_irq_asserts.sv
// Purpose: port checks of core_interrupt_control
// Assumes: one clock, sync reset
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
`include "core_irq_regs.vh"
module core_irq_asserts (
  input wire logic i_clock, // clock
  input wire logic i_reset, // reset
  input wire logic [`ADDR_W-1:0] i_addr, // address
  input wire logic [7:0] i_wdata, // wdata
  input wire logic i_wr, // write
  input wire logic i_rd, // read
  input wire logic [7:0] o_rdata, // rdata
  input wire logic i_timer0_overflow, // t0 event
  input wire logic o_core_irq, // request
  input wire logic o_irq // block irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // a write to any of the four mirrors of the control register
  wire cw = i_wr && (i_addr == `CORE_CTRL_ADDR_B0 || i_addr == `CORE_CTRL_ADDR_B1 ||
    i_addr == `CORE_CTRL_ADDR_B2 || i_addr == `CORE_CTRL_ADDR_B3);
  property p_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not zero");
  property p_mir; i_wr && i_addr == 9'h10B ##1 !i_wr ##1 i_rd && i_addr == 9'h18B
    |=> o_rdata[7:3] == $past(i_wdata[7:3], 3); endproperty
  a_mir: assert property (p_mir) else $error("mirror differs");
  property p_pie; i_wr && i_addr == 9'h08C ##1 !i_wr ##1 i_rd && i_addr == 9'h08C
    |=> o_rdata == ($past(i_wdata, 3) & 8'h4F); endproperty
  a_pie: assert property (p_pie) else $error("enable readback");
  property p_gie; cw && !i_wdata[7] |=> !o_core_irq; endproperty
  a_gie: assert property (p_gie) else $error("request without global");
  property p_peripheral_master_enable; cw && i_wdata[6:3] == 4'h0 |=> !o_core_irq; endproperty
  a_peripheral_master_enable: assert property (p_peripheral_master_enable) else $error("request without masters");
  property p_req; cw && i_wdata[7] && i_wdata[5] && i_wdata[2] |=> o_core_irq; endproperty
  a_req: assert property (p_req) else $error("request missing");
  property p_win; cw && i_wdata[7] && i_wdata[5] && i_timer0_overflow |=> o_core_irq; endproperty
  a_win: assert property (p_win) else $error("event lost");
  property p_mask; i_wr && i_addr == 9'h1F2 && i_wdata == 8'h00 |=> !o_irq; endproperty
  a_mask: assert property (p_mask) else $error("masked irq high");
  c_req: cover property ($rose(o_core_irq));
  c_irq: cover property ($rose(o_irq));
  c_win: cover property (cw && i_timer0_overflow);
endmodule
`default_nettype wire

//--- verification/irq_core_model.sv
// Purpose: core side taking the request
// Assumes: level request on the core clock
// Notes: never acknowledges; software clears flags
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
  input wire logic i_clock, // clock
  input wire logic i_reset, // reset
  input wire logic i_irq, // request
  output logic [7:0] o_taken // rises seen
);
  logic irq_r;
  always_ff @(posedge i_clock) begin
    irq_r <= i_reset ? 1'b0 : i_irq;
    if (i_reset) o_taken <= 8'h00;
    else if (i_irq && !irq_r) o_taken <= o_taken + 8'h01;
  end
endmodule
`default_nettype wire

//--- verification/tb_core_interrupt_control.sv
// Purpose: self-checking bench
// Assumes: 4 ns clock
// Notes: cc/pe/pf model the registers
`timescale 1ns/1ps
`default_nettype none
module tb_core_interrupt_control;
  logic i_clock = 0, i_reset = 1, i_wr = 0, i_rd = 0, pin = 0;
  logic [8:0] i_addr = 0;
  logic [7:0] i_wdata = 0, cc = 0, pe = 0, pf = 0, v;
  logic [6:0] ev = 0;
  wire [7:0] o_rdata, seen;
  wire o_core_irq, o_irq;
  int failures = 0, check_count = 0, k;
  always #2 i_clock = ~i_clock;
  core_interrupt_control DUT (.i_clock, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_timer0_overflow(ev[0]), .i_port_change(ev[1]), .i_ext_pin(pin), .i_conv_done(ev[2]),
    .i_serial_done(ev[3]), .i_capcmp_event(ev[4]), .i_timer2_match(ev[5]),
    .i_timer1_overflow(ev[6]), .o_core_irq, .o_irq);
  irq_core_model core (.i_clock, .i_reset, .i_irq(o_core_irq), .o_taken(seen));
  function logic xirq();
    return cc[7] & (|(cc[5:3] & cc[2:0]) | cc[6] & |(pe & pf));
  endfunction
  task chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [8:0] a, input logic [7:0] d, input logic [6:0] e = 0);
    @(posedge i_clock) {i_wr, i_addr, i_wdata, ev} <= {1'b1, a, d, e};
    @(posedge i_clock) {i_wr, ev} <= 0;
    #1;
  endtask
  task rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge i_clock) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clock) i_rd <= 0;
    #1 chk(o_rdata, e);
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #8000;
    failures++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h8AD7F695));
    repeat (8) @(posedge i_clock);
    i_reset <= 0;
    rd(9'h00B, 8'h00);
    rd(9'h08C, 8'h00);
    for (k = 0; k < 4; k++) begin
      v = $urandom & 8'h7F;
      wr(9'(11 + 128 * k), v);
      cc = v;
      rd(9'(11 + 128 * ((k + 1) % 4)), cc);
      chk(o_core_irq, xirq());
    end
    v = $urandom;
    wr(9'h08C, v);
    rd(9'h08C, v & 8'h4F);
    wr(9'h08C, 8'h00);
    wr(9'h00B, 8'h00);
    wr(9'h00C, 8'h00);
    {cc, pf} = 0;
    @(posedge i_clock) {ev, pin} <= {7'h7F, 1'b1};
    @(posedge i_clock) ev <= 0;
    rd(9'h08B, 8'h07);
    pf = 8'h4F;
    rd(9'h00C, pf);
    wr(9'h1F0, 8'h00);
    wr(9'h00B, 8'h00);
    @(posedge i_clock) pin <= 0;
    rd(9'h10B, 8'h02);
    for (k = 0; k < 8; k++) begin
      wr(9'h08C, 8'(1 << k));
      pe = 8'(1 << k) & 8'h4F;
      wr(9'h00B, 8'hC0);
      cc = 8'hC0;
      chk(o_core_irq, xirq());
      wr(9'h00B, 8'h80);
      cc = 8'h80;
      chk(o_core_irq, xirq());
    end
    chk(seen, 8'h05);
    wr(9'h10B, 8'hA0, 7'h01);
    cc = 8'hA4;
    rd(9'h18B, cc);
    wr(9'h00C, 8'h00, 7'h04);
    rd(9'h00C, 8'h40);
    wr(9'h1F2, 8'h01);
    chk(o_irq, 1'b1);
    wr(9'h1F1, 8'h03);
    chk(o_irq, 1'b0);
    wr(9'h00B, 8'h00);
    wr(9'h00B, 8'hA4);
    @(posedge i_clock) #1 chk(o_irq, 1'b1);
    wr(9'h1F2, 8'h00);
    chk(o_irq, 1'b0);
    rd(9'h155, 8'h00);
    report_and_stop;
  end
endmodule
bind core_interrupt_control core_irq_asserts chk_i (.i_clock, .i_reset, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_timer0_overflow, .o_core_irq, .o_irq);
`default_nettype wire
